/* File: common/tcsfs_cfg.svh */
// Constants of the timing-cap and sense fault supervisor.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef TCSFS_CFG_SVH
`define TCSFS_CFG_SVH

// ==========================================================
// Clock and delay times
`define TCSFS_CLK_HZ 32'd20000000
`define TCSFS_POR_TIME_US 32'd100000
`define TCSFS_REARM_TIME_US 32'd50000
`define TCSFS_SENSE_TIME_US 32'd100
`define TCSFS_US_CYCLES(us) ((us) * (`TCSFS_CLK_HZ / 32'd1000000))
`define TCSFS_POR_CYCLES `TCSFS_US_CYCLES(`TCSFS_POR_TIME_US)
`define TCSFS_REARM_CYCLES `TCSFS_US_CYCLES(`TCSFS_REARM_TIME_US)
`define TCSFS_SENSE_CYCLES `TCSFS_US_CYCLES(`TCSFS_SENSE_TIME_US)

// ==========================================================
// Register map (byte addresses)
`define TCSFS_ADDR_STATE 4'h0
`define TCSFS_ADDR_INT_STATUS 4'h4
`define TCSFS_ADDR_INT_ENABLE 4'h8
`define TCSFS_ADDR_INT_CLEAR 4'hc

// ==========================================================
// State register bits
`define TCSFS_ST_HW_FAULT 0
`define TCSFS_ST_CUR_FAULT 1
`define TCSFS_ST_GATE 2
`define TCSFS_ST_BREAKER 3
`define TCSFS_ST_POR_DONE 4
`define TCSFS_ST_ARMED 5

// Interrupt event bits
`define TCSFS_EV_HW_FAULT 0
`define TCSFS_EV_CUR_TRIP 1
`define TCSFS_EV_SENSE_TRIP 2
`define TCSFS_EV_POR_DONE 3
`define TCSFS_EV_WIDTH 4
`define TCSFS_INT_ENABLE_RST 4'h0

// Synchronised input bits
`define TCSFS_IN_ENABLE 0
`define TCSFS_IN_CAP_HIGH 1
`define TCSFS_IN_CAP_LOW 2
`define TCSFS_IN_OVERCUR 3
`define TCSFS_IN_MISMATCH 4
`define TCSFS_IN_REG_OK 5
`define TCSFS_IN_WIDTH 6

`endif

/* File: common/tcsfs_pkg.sv */
// Types of the timing-cap and sense fault supervisor.
// Used by scope; nothing imports it.
package tcsfs_pkg;

	// Gray along power-on wait -> run; fault start leaves run code
	typedef enum logic [1:0] {
		TCSFS_POR_WAIT = 2'b00,
		TCSFS_RUN = 2'b01,
		TCSFS_START_FAULT = 2'b11
	} tcsfs_start_t;

endpackage : tcsfs_pkg

/* File: hdl/tcsfs_delay.sv */
// Saturating delay timer: counts while run_i, restarts when it drops.
// Assumes run_i comes from logic on the same clock.
`timescale 1ns/1ps
module tcsfs_delay #(
	parameter logic [31:0] LENGTH = 32'd100
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	output logic expired_o
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	always_comb
	begin
		cnt_d = 32'h0;
		if (run_i)
			cnt_d = (cnt_q == LENGTH) ? cnt_q : cnt_q + 32'h1;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_d;
	end

	assign expired_o = run_i && (cnt_q == LENGTH);

	// ==========================================================
	// Checks
	property p_delay_len;
		@(posedge clk_i) disable iff (!resetn_i)
		$rose(expired_o) |-> cnt_q == LENGTH && $past(cnt_q) == LENGTH - 1;
	endproperty
	a_delay_len: assert property (p_delay_len)
		else $error("delay expired at wrong count");

endmodule : tcsfs_delay

/* File: hdl/tcsfs_supervisor.sv */
// Fault supervisor for the primary timing capacitor and load sense.
// Assumes comparators and the enable pin are asynchronous levels and
// resetn_i is the regulator lower-lockout indication.
`timescale 1ns/1ps
`include "tcsfs_cfg.svh"
module tcsfs_supervisor #(
	parameter logic [31:0] POR_CYCLES = `TCSFS_POR_CYCLES,
	parameter logic [31:0] REARM_CYCLES = `TCSFS_REARM_CYCLES,
	parameter logic [31:0] SENSE_CYCLES = `TCSFS_SENSE_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic cap_high_i,
	input wire logic cap_low_i,
	input wire logic overcurrent_i,
	input wire logic load_sense_mismatch_i,
	input wire logic reg_above_upper_i,
	output logic hardware_fault_out_o,
	output logic current_fault_out_o,
	output logic gate_drive_en_o,
	output logic fault_pulldown_en_o,
	output logic discharge_out_o,
	output logic cap_pin_discharge_o,
	output logic cap_charge_en_o,
	output logic irq_o,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	localparam int EVW = `TCSFS_EV_WIDTH;

	// ==========================================================
	// Input synchronisation
	logic [`TCSFS_IN_WIDTH-1:0] raw_in;
	logic [`TCSFS_IN_WIDTH-1:0] sync_in;
	logic enable_s;
	logic cap_high_s;
	logic cap_low_s;
	logic oc_s;
	logic mismatch_s;
	logic reg_ok_s;

	always_comb
	begin
		raw_in = '0;
		raw_in[`TCSFS_IN_ENABLE] = enable_i;
		raw_in[`TCSFS_IN_CAP_HIGH] = cap_high_i;
		raw_in[`TCSFS_IN_CAP_LOW] = cap_low_i;
		raw_in[`TCSFS_IN_OVERCUR] = overcurrent_i;
		raw_in[`TCSFS_IN_MISMATCH] = load_sense_mismatch_i;
		raw_in[`TCSFS_IN_REG_OK] = reg_above_upper_i;
	end

	tcsfs_sync #(.WIDTH(`TCSFS_IN_WIDTH)) u_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.async_i(raw_in),
		.sync_o(sync_in)
	);

	assign enable_s = sync_in[`TCSFS_IN_ENABLE];
	assign cap_high_s = sync_in[`TCSFS_IN_CAP_HIGH];
	assign cap_low_s = sync_in[`TCSFS_IN_CAP_LOW];
	assign oc_s = sync_in[`TCSFS_IN_OVERCUR];
	assign mismatch_s = sync_in[`TCSFS_IN_MISMATCH];
	assign reg_ok_s = sync_in[`TCSFS_IN_REG_OK];

	// ==========================================================
	// Fault state
	tcsfs_pkg::tcsfs_start_t start_q, start_d;
	logic hw_fault_q, hw_fault_d;
	logic cur_fault_q, cur_fault_d;
	logic brk_q, brk_d;
	logic gate_q, gate_d;
	logic armed_q, armed_d;
	logic charge_q, charge_d;
	logic enable_dly_q;
	logic por_exp;
	logic rearm_exp;
	logic sense_exp;
	logic por_done;
	logic steady_short;
	logic sense_trip;
	logic en_rise;
	logic en_fall;
	logic [EVW-1:0] events;

	assign por_done = (start_q != tcsfs_pkg::TCSFS_POR_WAIT);
	assign en_rise = enable_s && !enable_dly_q;
	assign en_fall = !enable_s && enable_dly_q;
	// Overcurrent blanks detection at once, not only after the arm flop
	assign steady_short = armed_q && !oc_s && por_done && cap_low_s;
	assign sense_trip = mismatch_s && gate_q;

	tcsfs_delay #(.LENGTH(POR_CYCLES)) u_por (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(reg_ok_s && !por_done),
		.expired_o(por_exp)
	);

	tcsfs_delay #(.LENGTH(REARM_CYCLES)) u_rearm (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(!armed_q && !oc_s),
		.expired_o(rearm_exp)
	);

	tcsfs_delay #(.LENGTH(SENSE_CYCLES)) u_sense (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(oc_s && cap_low_s && !brk_q),
		.expired_o(sense_exp)
	);

	always_comb
	begin
		start_d = start_q;
		hw_fault_d = hw_fault_q;
		cur_fault_d = cur_fault_q;
		brk_d = brk_q;
		gate_d = gate_q;
		armed_d = armed_q;
		charge_d = 1'b1;
		case (start_q)
			tcsfs_pkg::TCSFS_POR_WAIT:
			begin
				if (por_exp)
				begin
					if (cap_high_s)
						start_d = tcsfs_pkg::TCSFS_RUN;
					else
					begin
						start_d = tcsfs_pkg::TCSFS_START_FAULT;
						hw_fault_d = 1'b1;
					end
				end
			end
			tcsfs_pkg::TCSFS_RUN,
			tcsfs_pkg::TCSFS_START_FAULT:
				start_d = start_q;
			default:
				start_d = tcsfs_pkg::TCSFS_POR_WAIT;
		endcase
		if (oc_s)
			armed_d = 1'b0;
		else if (rearm_exp)
		begin
			armed_d = 1'b1;
			if (!cap_high_s)
				hw_fault_d = 1'b1;
		end
		if (steady_short)
			hw_fault_d = 1'b1;
		if (en_fall)
		begin
			brk_d = 1'b0;
			cur_fault_d = 1'b0;
			gate_d = 1'b0;
		end
		else if (en_rise && por_done && reg_ok_s && !brk_q)
			gate_d = 1'b1;
		if (sense_exp)
		begin
			brk_d = 1'b1;
			cur_fault_d = 1'b1;
			gate_d = 1'b0;
		end
		if (sense_trip)
		begin
			brk_d = 1'b1;
			gate_d = 1'b0;
		end
	end

	// Reset is the lower lockout: every latch and counter clears here except armed_q, which sets
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			start_q <= tcsfs_pkg::TCSFS_POR_WAIT;
			hw_fault_q <= 1'b0;
			cur_fault_q <= 1'b0;
			brk_q <= 1'b0;
			gate_q <= 1'b0;
			armed_q <= 1'b1;
			charge_q <= 1'b0;
			enable_dly_q <= 1'b0;
		end
		else
		begin
			start_q <= start_d;
			hw_fault_q <= hw_fault_d;
			cur_fault_q <= cur_fault_d;
			brk_q <= brk_d;
			gate_q <= gate_d;
			armed_q <= armed_d;
			charge_q <= charge_d;
			enable_dly_q <= enable_s;
		end
	end

	assign hardware_fault_out_o = hw_fault_q;
	assign current_fault_out_o = cur_fault_q;
	assign gate_drive_en_o = gate_q;
	assign fault_pulldown_en_o = brk_q;
	assign discharge_out_o = brk_q;
	assign cap_pin_discharge_o = !charge_q;
	assign cap_charge_en_o = charge_q;

	// ==========================================================
	// Interrupts and register slave
	logic [EVW-1:0] int_status_q, int_status_d;
	logic [EVW-1:0] int_enable_q, int_enable_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic wr_take;
	logic [31:0] state_word;

	function automatic logic addr_is(input logic [3:0] a,
		input logic [3:0] target);
		addr_is = (a == target);
	endfunction : addr_is

	always_comb
	begin
		events = '0;
		events[`TCSFS_EV_HW_FAULT] = hw_fault_d && !hw_fault_q;
		events[`TCSFS_EV_CUR_TRIP] = sense_exp && !brk_q;
		events[`TCSFS_EV_SENSE_TRIP] = sense_trip && !brk_q;
		events[`TCSFS_EV_POR_DONE] = por_exp;
		state_word = 32'h0;
		state_word[`TCSFS_ST_HW_FAULT] = hw_fault_q;
		state_word[`TCSFS_ST_CUR_FAULT] = cur_fault_q;
		state_word[`TCSFS_ST_GATE] = gate_q;
		state_word[`TCSFS_ST_BREAKER] = brk_q;
		state_word[`TCSFS_ST_POR_DONE] = por_done;
		state_word[`TCSFS_ST_ARMED] = armed_q;
	end

	// One wait cycle per access; answer in the second cycle
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
	assign wr_take = avs_write_i && ack_q;

	always_comb
	begin
		ack_d = (avs_read_i || avs_write_i) && !ack_q;
		rdata_d = rdata_q;
		if (avs_read_i && !ack_q)
		begin
			rdata_d = 32'h0;
			if (addr_is(avs_address_i, `TCSFS_ADDR_STATE))
				rdata_d = state_word;
			else if (addr_is(avs_address_i, `TCSFS_ADDR_INT_STATUS))
				rdata_d[EVW-1:0] = int_status_q;
			else if (addr_is(avs_address_i, `TCSFS_ADDR_INT_ENABLE))
				rdata_d[EVW-1:0] = int_enable_q;
		end
		int_enable_d = int_enable_q;
		if (wr_take && addr_is(avs_address_i, `TCSFS_ADDR_INT_ENABLE))
			int_enable_d = avs_writedata_i[EVW-1:0];
		int_status_d = int_status_q;
		if (wr_take && addr_is(avs_address_i, `TCSFS_ADDR_INT_CLEAR))
			int_status_d = int_status_q & ~avs_writedata_i[EVW-1:0];
		// A new event wins over a clear in the same cycle
		int_status_d = int_status_d | events;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			int_status_q <= '0;
			int_enable_q <= `TCSFS_INT_ENABLE_RST;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end
		else
		begin
			int_status_q <= int_status_d;
			int_enable_q <= int_enable_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign irq_o = |(int_status_q & int_enable_q);

	// ==========================================================
	// Checks
	property p_start_ok;
		@(posedge clk_i) disable iff (!resetn_i)
		por_exp && cap_high_s |=> start_q == tcsfs_pkg::TCSFS_RUN;
	endproperty
	a_start_ok: assert property (p_start_ok)
		else $error("run not entered with cap high at power-on expiry");

	property p_start_short;
		@(posedge clk_i) disable iff (!resetn_i)
		por_exp && !cap_high_s && !gate_q && !brk_q |=> hw_fault_q
			&& !gate_q && !brk_q;
	endproperty
	a_start_short: assert property (p_start_short)
		else $error("start-up short not flagged or touched gate");

	property p_hw_latched;
		@(posedge clk_i) disable iff (!resetn_i)
		hw_fault_q |=> hw_fault_q;
	endproperty
	a_hw_latched: assert property (p_hw_latched)
		else $error("hardware fault released without lockout");

	property p_steady;
		@(posedge clk_i) disable iff (!resetn_i)
		armed_q && !oc_s && por_done && cap_low_s && gate_q && !mismatch_s
			&& !en_fall |=> hw_fault_q && gate_q;
	endproperty
	a_steady: assert property (p_steady)
		else $error("steady-state short not flagged with gate kept");

	property p_oc_blank;
		@(posedge clk_i) disable iff (!resetn_i)
		oc_s |=> !armed_q;
	endproperty
	a_oc_blank: assert property (p_oc_blank)
		else $error("detection still armed during overcurrent");

	property p_rearm_fault;
		@(posedge clk_i) disable iff (!resetn_i)
		!armed_q && !oc_s && rearm_exp && !cap_high_s |=> armed_q
			&& hw_fault_q;
	endproperty
	a_rearm_fault: assert property (p_rearm_fault)
		else $error("re-arm expiry did not arm or flag low cap");

	property p_oc_trip;
		@(posedge clk_i) disable iff (!resetn_i)
		sense_exp |=> brk_q && cur_fault_q && !gate_q && discharge_out_o;
	endproperty
	a_oc_trip: assert property (p_oc_trip)
		else $error("sense delay expiry did not trip breaker");

	property p_gate_on;
		@(posedge clk_i) disable iff (!resetn_i)
		en_rise && por_done && reg_ok_s && !brk_q && !sense_exp
			&& !mismatch_s |=> gate_q;
	endproperty
	a_gate_on: assert property (p_gate_on)
		else $error("enable rise did not turn gate on");

	property p_mismatch;
		@(posedge clk_i) disable iff (!resetn_i)
		mismatch_s && gate_q |=> brk_q && !gate_q && fault_pulldown_en_o;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("load-sense mismatch did not trip breaker");

	property p_brk_clear;
		@(posedge clk_i) disable iff (!resetn_i)
		en_fall && !sense_exp && !sense_trip |=> !brk_q ##1 !brk_q;
	endproperty
	a_brk_clear: assert property (p_brk_clear)
		else $error("breaker not cleared by enable fall");

	property p_charge;
		@(posedge clk_i) disable iff (!resetn_i)
		$past(resetn_i) |-> cap_charge_en_o && !cap_pin_discharge_o;
	endproperty
	a_charge: assert property (p_charge)
		else $error("charge source not on after reset release");

endmodule : tcsfs_supervisor

/* File: hdl/tcsfs_sync.sv */
// Two-flop synchroniser bank for comparator and pin levels.
// Assumes inputs are asynchronous levels.
`timescale 1ns/1ps
module tcsfs_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

	// ==========================================================
	// Checks
	property p_sync_lag;
		@(posedge clk_i) disable iff (!resetn_i)
		sync_o != $past(sync_o) |-> sync_o == $past(async_i, 2);
	endproperty
	a_sync_lag: assert property (p_sync_lag)
		else $error("synchroniser output not two cycles behind input");

endmodule : tcsfs_sync

/* File: test/tb.sv */
// Self-checking bench for the timing-cap and sense fault supervisor.
// Assumes short delay parameters and the capacitor model beside it.
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] POR = 32'd20;
	localparam logic [31:0] REARM = 32'd10;
	localparam logic [31:0] SENSE = 32'd5;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic en = 1'b0;
	logic ovc = 1'b0;
	logic mism = 1'b0;
	logic reg_ok = 1'b0;
	logic shrt = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hw, cur, gate, pulld, discharge_out, pin_dis, chg, irq, c_hi, c_lo;
	logic [31:0] d;
	int bad_count = 0;
	int n_tests = 0;
	always #25 clk = ~clk;
	tcsfs_supervisor #(.POR_CYCLES(POR), .REARM_CYCLES(REARM),
		.SENSE_CYCLES(SENSE)) i_tcsfs_supervisor (.clk_i(clk),
		.resetn_i(resetn), .enable_i(en), .cap_high_i(c_hi),
		.cap_low_i(c_lo), .overcurrent_i(ovc),
		.load_sense_mismatch_i(mism), .reg_above_upper_i(reg_ok),
		.hardware_fault_out_o(hw), .current_fault_out_o(cur),
		.gate_drive_en_o(gate), .fault_pulldown_en_o(pulld),
		.discharge_out_o(discharge_out), .cap_pin_discharge_o(pin_dis),
		.cap_charge_en_o(chg), .irq_o(irq), .avs_address_i(avs_address),
		.avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest));
	tcsfs_cap_model i_tcsfs_cap_model (.clk_i(clk), .charge_en_i(chg),
		.pin_discharge_i(pin_dis), .drain_i(ovc), .short_i(shrt),
		.cap_high_o(c_hi), .cap_low_o(c_lo));
	// ==========================================================
	// Reporting
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task chk(input logic got, input logic exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task chkw(input logic [31:0] got, input logic [31:0] exp, string m);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s got %h", $time, m, got);
		end
	endtask : chkw
	task hang(input string m);
		bad_count++;
		$display("[FAIL] %0t timeout %s", $time, m);
		report_and_stop();
	endtask : hang
	// Ends mid-cycle so outputs are settled when looked at
	task cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc
	function automatic logic pick(input int s);
		case (s)
			0: return hw;
			1: return discharge_out;
			default: return gate;
		endcase
	endfunction : pick
	task wait_on(input int s, input int lim);
		int k;
		k = 0;
		while (pick(s) !== 1'b1 && k < lim)
		begin
			@(negedge clk);
			k++;
		end
		if (k >= lim)
			hang("output wait");
	endtask : wait_on
	// ==========================================================
	// Avalon-MM master
	task bus_acc(input logic rd, input logic [3:0] a, input logic [31:0] w);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= w;
		avs_read <= rd;
		avs_write <= !rd;
		@(negedge clk);
		k = 0;
		while (avs_waitrequest !== 1'b0 && k < 50)
		begin
			@(negedge clk);
			k++;
		end
		if (k >= 50)
			hang("bus");
		@(posedge clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus_acc
	// ==========================================================
	// Scenarios
	task do_reset(input logic sh);
		@(posedge clk);
		resetn <= 1'b0;
		{en, ovc, mism, reg_ok} <= 4'h0;
		shrt <= sh;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(pin_dis, 1'b1, "cap pin not held low");
		chk(chg | hw | gate | discharge_out | irq, 1'b0, "outputs in reset");
		@(posedge clk);
		resetn <= 1'b1;
		reg_ok <= 1'b1;
		cyc(2);
		chk(chg & !pin_dis, 1'b1, "charge source off");
	endtask : do_reset
	task s_start;
		cyc(3);
		@(posedge clk);
		en <= 1'b1;
		cyc(POR + 8);
		chk(gate, 1'b0, "early enable rise took effect");
		chk(hw, 1'b0, "fault on good start");
		@(posedge clk);
		en <= 1'b0;
		cyc(4);
		@(posedge clk);
		en <= 1'b1;
		wait_on(2, 10);
		chk(gate, 1'b1, "gate not on");
	endtask : s_start
	task s_regs;
		bus_acc(1'b1, 4'h0, 32'h0);
		chkw(d[5:0], 6'h34, "state");
		bus_acc(1'b0, 4'h0, 32'hffffffff);
		bus_acc(1'b1, 4'h0, 32'h0);
		chkw(d[5:0], 6'h34, "state written");
		bus_acc(1'b1, 4'h4, 32'h0);
		chkw(d[3:0], 4'h8, "status");
		chk(irq, 1'b0, "irq while masked");
		bus_acc(1'b0, 4'h8, 32'h8);
		cyc(1);
		chk(irq, 1'b1, "irq not raised");
		bus_acc(1'b0, 4'hc, 32'h8);
		cyc(1);
		chk(irq, 1'b0, "irq not cleared");
		bus_acc(1'b1, 4'h4, 32'h0);
		chkw(d[3:0], 4'h0, "status after clear");
		bus_acc(1'b1, 4'hc, 32'h0);
		chkw(d, 32'h0, "clear register readable");
	endtask : s_regs
	task s_steady_short;
		@(posedge clk);
		shrt <= 1'b1;
		wait_on(0, 20);
		chk(gate & !discharge_out, 1'b1, "gate dropped on short");
		@(posedge clk);
		en <= 1'b0;
		cyc(5);
		@(posedge clk);
		en <= 1'b1;
		cyc(5);
		chk(hw, 1'b1, "fault not latched");
		@(posedge clk);
		shrt <= 1'b0;
	endtask : s_steady_short
	task s_start_short;
		do_reset(1'b1);
		cyc(10);
		chk(hw, 1'b0, "fault before delay end");
		wait_on(0, 40);
		chk(gate | discharge_out | pulld, 1'b0, "gate or discharge moved");
	endtask : s_start_short
	task s_oc(input logic sh);
		@(posedge clk);
		ovc <= 1'b1;
		shrt <= sh;
		cyc(4);
		chk(gate, 1'b1, "trip before sense delay");
		wait_on(1, 30);
		chk(cur & pulld & !gate, 1'b1, "breaker outputs");
		chk(hw, 1'b0, "short flagged in overcurrent");
		@(posedge clk);
		ovc <= 1'b0;
		cyc(5);
		chk(hw, 1'b0, "detection back too soon");
		if (sh)
		begin
			wait_on(0, 30);
			chk(hw, 1'b1, "no fault at re-arm");
		end
		else
		begin
			cyc(REARM + 15);
			chk(hw, 1'b0, "false fault after recharge");
		end
		@(posedge clk);
		en <= 1'b0;
		cyc(5);
		chk(cur | pulld | discharge_out, 1'b0, "current fault not cleared");
	endtask : s_oc
	task s_mismatch;
		bus_acc(1'b0, 4'h8, 32'h4);
		@(posedge clk);
		mism <= 1'b1;
		wait_on(1, 20);
		chk(pulld & !gate & !hw, 1'b1, "mismatch trip");
		chk(irq, 1'b1, "trip event irq");
		@(posedge clk);
		mism <= 1'b0;
		cyc(10);
		chk(gate, 1'b0, "breaker left by itself");
		@(posedge clk);
		en <= 1'b0;
		cyc(5);
		chk(discharge_out | pulld, 1'b0, "breaker not cleared");
		@(posedge clk);
		en <= 1'b1;
		wait_on(2, 10);
		chk(gate, 1'b1, "gate not back");
	endtask : s_mismatch
	initial
	begin
		do_reset(1'b0);
		s_start();
		s_regs();
		s_steady_short();
		s_start_short();
		do_reset(1'b0);
		s_start();
		s_oc(1'b0);
		do_reset(1'b0);
		s_start();
		s_oc(1'b1);
		do_reset(1'b0);
		s_start();
		s_mismatch();
		report_and_stop();
	end
endmodule : tb

/* File: test/tcsfs_cap_model.sv */
// Behavioural timing capacitor and its comparators, facing the supervisor.
// Assumes one clock; the node level is a coarse stand-in for the voltage.
`timescale 1ns/1ps
module tcsfs_cap_model (
	input wire logic clk_i,
	input wire logic charge_en_i,
	input wire logic pin_discharge_i,
	input wire logic drain_i,
	input wire logic short_i,
	output logic cap_high_o,
	output logic cap_low_o
);
	logic [4:0] level_q = 5'h00;
	// ==========================================================
	// Capacitor node
	// Overcurrent drains faster than the source charges, as the real
	// primary timing discharge does; a short pins the node to ground.
	always @(posedge clk_i)
	begin
		if (pin_discharge_i || short_i)
			level_q <= 5'h00;
		else if (drain_i)
			level_q <= (level_q > 5'h04) ? level_q - 5'h04 : 5'h00;
		else if (charge_en_i && level_q < 5'h10)
			level_q <= level_q + 5'h02;
	end
	assign cap_high_o = (level_q >= 5'h0c);
	assign cap_low_o = (level_q < 5'h03);
endmodule : tcsfs_cap_model
